/* File: verilog/stop_seq_pkg.sv */
package stop_seq_pkg;
  // Register byte offsets on the Wishbone bus
  localparam logic [7:0] ADDR_GEAR2 = 8'h00;
  localparam logic [7:0] ADDR_GEAR3 = 8'h04;
  localparam logic [7:0] ADDR_GEAR4 = 8'h08;
  localparam logic [7:0] ADDR_PULSE_DIV = 8'h0c;
  localparam logic [7:0] ADDR_OT_SETUP = 8'h10;
  localparam logic [7:0] ADDR_OT_SEQ = 8'h14;
  localparam logic [7:0] ADDR_SOFF_SEQ = 8'h18;
  localparam logic [7:0] ADDR_PLOSS_SEQ = 8'h1c;
  localparam logic [7:0] ADDR_LV_TRIP = 8'h20;
  localparam logic [7:0] ADDR_ALARM_SEQ = 8'h24;
  localparam logic [7:0] ADDR_ESTOP_TRQ = 8'h28;
  localparam logic [7:0] ADDR_PPR = 8'h2c;
  localparam logic [7:0] ADDR_STATUS = 8'h30;
  localparam logic [7:0] ADDR_GEAR_OUT = 8'h34;

  // Field widths
  localparam int GEAR_W = 31;
  localparam int DIV_W = 21;
  localparam int TRQ_W = 9;

  // Limits and defaults
  localparam logic [GEAR_W-1:0] GEAR_MAX = 31'h40000000;
  localparam logic [DIV_W-1:0] DIV_MAX = 21'h100000;
  localparam logic [DIV_W-1:0] DIV_MAX_STD = 21'h040000;
  localparam logic [TRQ_W-1:0] TRQ_MAX = 9'h1f4;
  localparam logic [1:0] OT_SETUP_RST = 2'h1;
  localparam logic [1:0] OT_SETUP_MAX = 2'h2;
  localparam logic [1:0] OT_SEQ_MAX = 2'h2;
  localparam logic [3:0] SEQ_MAX = 4'h9;
  localparam logic [2:0] ALARM_SEQ_MAX = 3'h7;
  localparam logic LV_TRIP_RST = 1'b1;

  // Over-travel setup codes
  localparam logic [1:0] OT_INHIBIT = 2'h0;
  localparam logic [1:0] OT_FAULT = 2'h2;

  // Stop threshold in r/min
  localparam logic [15:0] STOP_SPEED_RPM = 16'h001e;

  typedef enum {ST_RUN, ST_DECEL, ST_STOPPED} phase_t;
  typedef enum {SRC_NONE, SRC_OT, SRC_SOFF, SRC_PLOSS, SRC_ALARM} source_t;
endpackage

/* File: verilog/servo_stop_sequence_selector.sv */
// The Wishbone slave port and the address map were decided locally.
`timescale 1ns/1ps
// Function
// - Three alternative gear numerators, up to 2^30
// - Alternatives apply only when ppr zero or closed
// - Position mode zero numerator uses encoder resolution
// - Full-closed zero numerator forces ratio one
// - Over-travel setup: inhibit, ignore, or fault
// - Over-travel sequence applies only with setup zero
// - Sequences 0/1: DB or zero torque, hold
// - Sequence 2: emergency stop, zero command, clear
// - Servo-off sequence 0-9 picks decel/stop actions
// - Values 0-3,8,9 clear deviation; 4-7 hold
// - Emergency stop keeps servo on, torque limited
// - Deceleration ends below 30 r/min
// - Held deviation keeps accumulating, may fault
// - Error during servo-off uses alarm sequence
// - Power loss during servo-off uses power sequence
// - Power-loss sequence decodes like servo-off
// - Error during power-off uses alarm sequence
// - Power loss at servo-on trips when selected
// - Power-cycle parameters latch at control power-on
// - Pulse divider range and power-on latching
// - Alarm holds deviation, clears on cancel
// - Zero estop torque uses normal limit
module servo_stop_sequence_selector
  import stop_seq_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Host pins, asynchronous
  input wire logic servo_on_input_i,
  input wire logic positive_limit_input_i,
  input wire logic negative_limit_input_i,
  // Drive status from the same clock domain
  input wire logic control_power_on_i,
  input wire logic main_power_ok_i,
  input wire logic alarm_i,
  input wire logic alarm_estop_i,
  input wire logic full_closed_i,
  input wire logic extended_variant_i,
  input wire logic [15:0] motor_speed_rpm_i,
  input wire logic motor_dir_neg_i,
  input wire logic [stop_seq_pkg::GEAR_W-1:0] encoder_resolution_i,
  input wire logic [stop_seq_pkg::GEAR_W-1:0] gear_denominator_i,
  input wire logic [1:0] gear_select_i,
  input wire logic [stop_seq_pkg::TRQ_W-1:0] normal_torque_limit_i,
  input wire logic deviation_excess_i,
  // Brake, torque, inhibit, fault, gear and divider outputs
  output logic dynamic_brake_o,
  output logic servo_energized_o,
  output logic estop_active_o,
  output logic [stop_seq_pkg::TRQ_W-1:0] torque_limit_o,
  output logic inhibit_pos_o,
  output logic inhibit_neg_o,
  output logic zero_command_o,
  output logic deviation_clear_o,
  output logic run_inhibit_fault_o,
  output logic mains_undervoltage_fault_o,
  output logic excess_deviation_fault_o,
  output logic [stop_seq_pkg::GEAR_W-1:0] gear_num_o,
  output logic [stop_seq_pkg::GEAR_W-1:0] gear_den_o,
  output logic [stop_seq_pkg::DIV_W-1:0] pulse_out_divider_o
);
  import stop_seq_pkg::*;

  // Software-written settings
  logic [GEAR_W-1:0] gear_numerator_second_ff;
  logic [GEAR_W-1:0] gear_numerator_third_ff;
  logic [GEAR_W-1:0] gear_numerator_fourth_ff;
  logic [DIV_W-1:0] pulse_out_divider_denominator_ff;
  logic [1:0] overtravel_setup_ff;
  logic [1:0] overtravel_stop_sequence_ff;
  logic [3:0] servo_off_stop_sequence_ff;
  logic [3:0] power_loss_stop_sequence_ff;
  logic low_voltage_trip_select_ff;
  logic [2:0] alarm_stop_sequence_ff;
  logic [TRQ_W-1:0] estop_torque_limit_ff;
  logic [GEAR_W-1:0] pulses_per_revolution_ff;
  // Active copies of power-cycle settings
  logic [DIV_W-1:0] act_divider_ff;
  logic [1:0] act_ot_setup_ff;
  logic [1:0] act_ot_seq_ff;
  logic cpwr_d_ff;

  // Synchronisers for host pins; bus ack and read data
  logic [2:0] pin_s1_ff;
  logic [2:0] pin_s2_ff;
  logic ack_ff;
  logic [31:0] rdat_ff;

  // Sequencing state
  phase_t phase_ff;
  phase_t nxt_phase;
  source_t src_ff;
  source_t nxt_src;
  logic servo_on_d_ff;
  logic alarm_d_ff;
  logic uv_fault_ff;
  logic ot_fault_ff;

  wire servo_on_s = pin_s2_ff[0];
  wire pos_lim_s = pin_s2_ff[1];
  wire neg_lim_s = pin_s2_ff[2];

  // Two-flop synchronisers; first stage is read only by the second
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      pin_s1_ff <= 3'h0;
      pin_s2_ff <= 3'h0;
    end
    else
    begin
      pin_s1_ff <= {negative_limit_input_i, positive_limit_input_i, servo_on_input_i};
      pin_s2_ff <= pin_s1_ff;
    end
  end

  // Bus decode; one wait state, ack drops the cycle after it is given
  wire bus_req = wb_cyc_i && wb_stb_i && !ack_ff;
  wire bus_wr = bus_req && wb_we_i && (wb_sel_i == 4'hf);
  wire [31:0] wd = wb_dat_i;
  wire [DIV_W-1:0] div_lim = extended_variant_i ? DIV_MAX : DIV_MAX_STD;
  // Out-of-range writes are ignored, except at ADDR_LV_TRIP, which keeps bit 0; no setting leaves its range
  wire gear_ok = wd[GEAR_W-1:0] <= GEAR_MAX && wd[31] == 1'b0;
  wire div_ok = wd[DIV_W-1:0] <= div_lim && wd[31:DIV_W] == 11'h000;
  wire seq_ok = wd[3:0] <= SEQ_MAX && wd[31:4] == 28'h0000000;
  wire ot_ok = wd[1:0] <= OT_SETUP_MAX && wd[31:2] == 30'h00000000;
  wire ots_ok = wd[1:0] <= OT_SEQ_MAX && wd[31:2] == 30'h00000000;
  wire als_ok = wd[2:0] <= ALARM_SEQ_MAX && wd[31:3] == 29'h00000000;
  wire trq_ok = wd[TRQ_W-1:0] <= TRQ_MAX && wd[31:TRQ_W] == 23'h000000;

  // Setting registers, reset to their defaults
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      gear_numerator_second_ff <= '0;
      gear_numerator_third_ff <= '0;
      gear_numerator_fourth_ff <= '0;
      pulse_out_divider_denominator_ff <= '0;
      overtravel_setup_ff <= OT_SETUP_RST;
      overtravel_stop_sequence_ff <= 2'h0;
      servo_off_stop_sequence_ff <= 4'h0;
      power_loss_stop_sequence_ff <= 4'h0;
      low_voltage_trip_select_ff <= LV_TRIP_RST;
      alarm_stop_sequence_ff <= 3'h0;
      estop_torque_limit_ff <= '0;
      pulses_per_revolution_ff <= '0;
    end
    else if (bus_wr)
    begin
      case (wb_adr_i)
        ADDR_GEAR2: if (gear_ok) gear_numerator_second_ff <= wd[GEAR_W-1:0];
        ADDR_GEAR3: if (gear_ok) gear_numerator_third_ff <= wd[GEAR_W-1:0];
        ADDR_GEAR4: if (gear_ok) gear_numerator_fourth_ff <= wd[GEAR_W-1:0];
        ADDR_PULSE_DIV: if (div_ok) pulse_out_divider_denominator_ff <= wd[DIV_W-1:0];
        ADDR_OT_SETUP: if (ot_ok) overtravel_setup_ff <= wd[1:0];
        ADDR_OT_SEQ: if (ots_ok) overtravel_stop_sequence_ff <= wd[1:0];
        ADDR_SOFF_SEQ: if (seq_ok) servo_off_stop_sequence_ff <= wd[3:0];
        ADDR_PLOSS_SEQ: if (seq_ok) power_loss_stop_sequence_ff <= wd[3:0];
        ADDR_LV_TRIP: low_voltage_trip_select_ff <= wd[0];
        ADDR_ALARM_SEQ: if (als_ok) alarm_stop_sequence_ff <= wd[2:0];
        ADDR_ESTOP_TRQ: if (trq_ok) estop_torque_limit_ff <= wd[TRQ_W-1:0];
        ADDR_PPR: if (gear_ok) pulses_per_revolution_ff <= wd[GEAR_W-1:0];
        default: ;
      endcase
    end
  end

  // Power-cycle settings copy in on the rising edge of control power
  wire cpwr_rise = control_power_on_i && !cpwr_d_ff;
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      cpwr_d_ff <= 1'b0;
      act_divider_ff <= '0;
      act_ot_setup_ff <= OT_SETUP_RST;
      act_ot_seq_ff <= 2'h0;
    end
    else
    begin
      cpwr_d_ff <= control_power_on_i;
      if (cpwr_rise)
      begin
        act_divider_ff <= pulse_out_divider_denominator_ff;
        act_ot_setup_ff <= overtravel_setup_ff;
        act_ot_seq_ff <= overtravel_stop_sequence_ff;
      end
    end
  end

  // Gear numerator selection
  wire [GEAR_W-1:0] alt_num = (gear_select_i == 2'h1) ? gear_numerator_second_ff :
                              (gear_select_i == 2'h2) ? gear_numerator_third_ff :
                              gear_numerator_fourth_ff;
  wire alt_active = (gear_select_i != 2'h0) &&
                    ((pulses_per_revolution_ff == '0) || full_closed_i);
  wire alt_zero = (alt_num == '0);
  wire [GEAR_W-1:0] one_g = {{(GEAR_W-1){1'b0}}, 1'b1};
  wire [GEAR_W-1:0] sel_num = !alt_active ? encoder_resolution_i :
                              !alt_zero ? alt_num :
                              full_closed_i ? one_g : encoder_resolution_i;
  wire [GEAR_W-1:0] sel_den = (alt_active && alt_zero && full_closed_i) ?
                              one_g : gear_denominator_i;

  // Over-travel handling
  wire ot_mode_inh = (act_ot_setup_ff == OT_INHIBIT);
  wire ot_hit = ot_mode_inh && (pos_lim_s || neg_lim_s);
  wire ot_fault_req = (act_ot_setup_ff == OT_FAULT) && (pos_lim_s || neg_lim_s);

  // Stop detection: below threshold is stopped regardless of later speed
  wire below_stop = motor_speed_rpm_i < STOP_SPEED_RPM;
  wire fault_any = alarm_i || uv_fault_ff || ot_fault_ff || deviation_excess_i;
  wire servo_on_fall = servo_on_d_ff && !servo_on_s;
  wire uv_trip = servo_on_s && !main_power_ok_i && low_voltage_trip_select_ff;
  wire alarm_cancel = alarm_d_ff && !fault_any;

  // Source priority: alarm over power loss over servo-off over over-travel
  always_comb
  begin
    nxt_src = src_ff;
    if (fault_any)
      nxt_src = SRC_ALARM;
    else if (!main_power_ok_i)
      nxt_src = SRC_PLOSS;
    else if (!servo_on_s)
      nxt_src = SRC_SOFF;
    else if (ot_hit)
      nxt_src = SRC_OT;
    else
      nxt_src = SRC_NONE;
  end

  // Phase machine: run, decelerate, stopped
  always_comb
  begin
    nxt_phase = phase_ff;
    case (phase_ff)
      ST_RUN: if (nxt_src != SRC_NONE) nxt_phase = ST_DECEL;
      ST_DECEL:
      begin
        if (nxt_src == SRC_NONE)
          nxt_phase = ST_RUN;
        else if (below_stop)
          nxt_phase = ST_STOPPED;
      end
      ST_STOPPED: if (nxt_src == SRC_NONE) nxt_phase = ST_RUN;
      default: nxt_phase = ST_RUN;
    endcase
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      phase_ff <= ST_RUN;
      src_ff <= SRC_NONE;
      servo_on_d_ff <= 1'b0;
      alarm_d_ff <= 1'b0;
      uv_fault_ff <= 1'b0;
      ot_fault_ff <= 1'b0;
    end
    else
    begin
      phase_ff <= nxt_phase;
      src_ff <= nxt_src;
      servo_on_d_ff <= servo_on_s;
      alarm_d_ff <= fault_any;
      // Faults hold only while the alarm input stays high and clear when it drops; set wins
      uv_fault_ff <= uv_trip || (uv_fault_ff && alarm_i);
      ot_fault_ff <= ot_fault_req || (ot_fault_ff && alarm_i);
    end
  end

  // Servo-off style decode (shared by power-loss sequence)
  wire [3:0] sq = (src_ff == SRC_PLOSS) ? power_loss_stop_sequence_ff :
                  servo_off_stop_sequence_ff;
  wire sq_estop = (sq >= 4'h8);
  wire sq_dec_db = !sq_estop && !sq[0];
  wire sq_post_db = sq_estop ? !sq[0] : !sq[1];
  wire sq_hold = (sq >= 4'h4) && (sq <= 4'h7);
  // Alarm decode; estop variants only for alarms that ask for one
  wire al_estop = alarm_stop_sequence_ff[2] && alarm_estop_i;
  wire al_dec_db = alarm_stop_sequence_ff[2] ? !alarm_stop_sequence_ff[0] :
                   !alarm_stop_sequence_ff[0];
  wire al_post_db = !alarm_stop_sequence_ff[1];

  wire decel = (phase_ff == ST_DECEL);
  wire stopped = (phase_ff == ST_STOPPED);
  wire is_ot = (src_ff == SRC_OT);
  wire is_al = (src_ff == SRC_ALARM);
  wire is_sq = (src_ff == SRC_SOFF) || (src_ff == SRC_PLOSS);

  wire ot_estop = is_ot && decel && (act_ot_seq_ff == 2'h2);
  wire ot_db = is_ot && decel && (act_ot_seq_ff == 2'h0);
  wire estop_now = ot_estop || (decel && ((is_sq && sq_estop) || (is_al && al_estop)));
  wire db_now = ot_db ||
                (is_sq && !estop_now && (decel ? sq_dec_db : stopped && sq_post_db)) ||
                (is_al && !estop_now && (decel ? al_dec_db : stopped && al_post_db));
  // Energised while running, under over-travel torque limiting, or estop
  wire energize = (src_ff == SRC_NONE) || (is_ot && !ot_db) || estop_now;
  wire dev_clear = (is_ot && act_ot_seq_ff == 2'h2) ||
                   (is_sq && !sq_hold) || (is_al && alarm_cancel);
  wire [TRQ_W-1:0] trq = (estop_now && estop_torque_limit_ff != '0) ?
                         estop_torque_limit_ff : normal_torque_limit_i;
  wire dir_inh_p = is_ot && pos_lim_s;
  wire dir_inh_n = is_ot && neg_lim_s;

  // Registered outputs
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      dynamic_brake_o <= 1'b0;
      servo_energized_o <= 1'b0;
      estop_active_o <= 1'b0;
      torque_limit_o <= '0;
      inhibit_pos_o <= 1'b0;
      inhibit_neg_o <= 1'b0;
      zero_command_o <= 1'b0;
      deviation_clear_o <= 1'b0;
      gear_num_o <= '0;
      gear_den_o <= '0;
      pulse_out_divider_o <= '0;
    end
    else
    begin
      dynamic_brake_o <= db_now;
      servo_energized_o <= energize;
      estop_active_o <= estop_now;
      torque_limit_o <= trq;
      inhibit_pos_o <= dir_inh_p;
      inhibit_neg_o <= dir_inh_n;
      zero_command_o <= is_ot && stopped && (act_ot_seq_ff == 2'h2);
      deviation_clear_o <= dev_clear;
      gear_num_o <= sel_num;
      gear_den_o <= sel_den;
      pulse_out_divider_o <= act_divider_ff;
    end
  end

  assign run_inhibit_fault_o = ot_fault_ff;
  assign mains_undervoltage_fault_o = uv_fault_ff;
  assign excess_deviation_fault_o = deviation_excess_i && !deviation_clear_o;

  // Read mux; unmapped addresses read zero and are still acknowledged
  wire [31:0] status_w = {24'h000000, alarm_d_ff, ot_fault_ff, uv_fault_ff,
                          stopped, decel, servo_on_s, neg_lim_s, pos_lim_s};
  wire [31:0] rd_mux =
    (wb_adr_i == ADDR_GEAR2) ? {1'b0, gear_numerator_second_ff} :
    (wb_adr_i == ADDR_GEAR3) ? {1'b0, gear_numerator_third_ff} :
    (wb_adr_i == ADDR_GEAR4) ? {1'b0, gear_numerator_fourth_ff} :
    (wb_adr_i == ADDR_PULSE_DIV) ? {11'h000, pulse_out_divider_denominator_ff} :
    (wb_adr_i == ADDR_OT_SETUP) ? {30'h00000000, overtravel_setup_ff} :
    (wb_adr_i == ADDR_OT_SEQ) ? {30'h00000000, overtravel_stop_sequence_ff} :
    (wb_adr_i == ADDR_SOFF_SEQ) ? {28'h0000000, servo_off_stop_sequence_ff} :
    (wb_adr_i == ADDR_PLOSS_SEQ) ? {28'h0000000, power_loss_stop_sequence_ff} :
    (wb_adr_i == ADDR_LV_TRIP) ? {31'h00000000, low_voltage_trip_select_ff} :
    (wb_adr_i == ADDR_ALARM_SEQ) ? {29'h00000000, alarm_stop_sequence_ff} :
    (wb_adr_i == ADDR_ESTOP_TRQ) ? {23'h000000, estop_torque_limit_ff} :
    (wb_adr_i == ADDR_PPR) ? {1'b0, pulses_per_revolution_ff} :
    (wb_adr_i == ADDR_STATUS) ? status_w :
    (wb_adr_i == ADDR_GEAR_OUT) ? {1'b0, gear_num_o} : 32'h00000000;

  // Acknowledge one cycle after the request
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ack_ff <= 1'b0;
      rdat_ff <= 32'h00000000;
    end
    else
    begin
      ack_ff <= bus_req;
      if (bus_req)
        rdat_ff <= rd_mux;
    end
  end

  assign wb_ack_o = ack_ff;
  assign wb_dat_o = rdat_ff;
endmodule

/* File: sim/servo_stop_sequence_selector_props.sv */
`timescale 1ns/1ps
module stop_seq_props (
  // Clock, reset and bus handshake
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  // Drive status and stop paths
  input wire logic alarm_i,
  input wire logic main_power_ok_i,
  input wire logic deviation_excess_i,
  input wire logic dynamic_brake_o,
  input wire logic servo_energized_o,
  input wire logic estop_active_o,
  input wire logic deviation_clear_o,
  input wire logic mains_undervoltage_fault_o,
  input wire logic excess_deviation_fault_o
);
  import stop_seq_pkg::*;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  // Bus answers exactly one cycle after a taken request, as a single pulse
  a_ack_after_req: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("no ack after request");
  a_ack_one_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  // Outputs leave reset quiet
  a_reset_quiet: assert property ($fell(rst_i) |-> !dynamic_brake_o && !estop_active_o)
    else $error("stop outputs active after reset");
  // Emergency stop is a controlled stop, so the servo stays energized
  a_estop_energized: assert property (estop_active_o |-> servo_energized_o)
    else $error("emergency stop without servo on");
  // A settled alarm keeps the deviation; cancel clears it soon after
  a_alarm_hold_dev: assert property (alarm_i [*4] |-> !deviation_clear_o)
    else $error("deviation cleared during alarm");
  a_alarm_cancel_clr: assert property ($fell(alarm_i) |-> ##[1:3] deviation_clear_o)
    else $error("deviation not cleared at alarm cancel");
  // Undervoltage trip needs missing mains
  a_uv_needs_loss: assert property ($rose(mains_undervoltage_fault_o) |-> !$past(main_power_ok_i))
    else $error("undervoltage fault with mains present");
  // Excess fault only from an accumulated deviation
  a_excess_cause: assert property (excess_deviation_fault_o |-> deviation_excess_i)
    else $error("excess fault without excess deviation");
endmodule

bind servo_stop_sequence_selector stop_seq_props props (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i,
  .wb_ack_o, .alarm_i, .main_power_ok_i, .deviation_excess_i, .dynamic_brake_o,
  .servo_energized_o, .estop_active_o, .deviation_clear_o, .mains_undervoltage_fault_o,
  .excess_deviation_fault_o);

/* File: sim/host_ctrl_model.sv */
`timescale 1ns/1ps
module host_ctrl_model (
  // Clock
  input wire logic clk_i,
  // Host pins toward the drive
  output logic servo_on_input_o,
  output logic positive_limit_input_o,
  output logic negative_limit_input_o
);
  // Released pins: servo off, no limit reached
  initial
  begin
    servo_on_input_o = 1'b0;
    positive_limit_input_o = 1'b0;
    negative_limit_input_o = 1'b0;
  end

  // New levels after a host lag; a slow host tests late edges at the synchronizer
  task automatic drive(input logic son, input logic pos, input logic neg, input int lag);
    repeat (lag + 1) @(posedge clk_i);
    servo_on_input_o <= son;
    positive_limit_input_o <= pos;
    negative_limit_input_o <= neg;
  endtask
endmodule

/* File: sim/tb_servo_stop_sequence_selector.sv */
`timescale 1ns/1ps
module tb_servo_stop_sequence_selector;
  import stop_seq_pkg::*;
  // Stimulus
  logic clk_i = 1'b0, rst_i = 1'b1, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [3:0] wb_sel_i = 4'hf;
  logic [31:0] wb_dat_i = 32'h0;
  logic control_power_on_i = 1'b1, main_power_ok_i = 1'b1, alarm_i = 1'b0;
  logic alarm_estop_i = 1'b0, full_closed_i = 1'b0, extended_variant_i = 1'b0;
  logic motor_dir_neg_i = 1'b0, deviation_excess_i = 1'b0;
  logic [15:0] motor_speed_rpm_i = 16'h03e8;
  logic [GEAR_W-1:0] encoder_resolution_i = 31'h00020000;
  logic [GEAR_W-1:0] gear_denominator_i = 31'h00002710;
  logic [1:0] gear_select_i = 2'h0;
  logic [TRQ_W-1:0] normal_torque_limit_i = 9'h12c;
  // Observed
  logic [31:0] wb_dat_o;
  logic wb_ack_o, dynamic_brake_o, servo_energized_o, estop_active_o, inhibit_pos_o;
  logic inhibit_neg_o, zero_command_o, deviation_clear_o, run_inhibit_fault_o;
  logic mains_undervoltage_fault_o, excess_deviation_fault_o;
  logic [TRQ_W-1:0] torque_limit_o;
  logic [GEAR_W-1:0] gear_num_o, gear_den_o;
  logic [DIV_W-1:0] pulse_out_divider_o;
  wire servo_on_input_i, positive_limit_input_i, negative_limit_input_i;
  int error_cnt = 0, checks_done = 0;

  always #25 clk_i = ~clk_i;

  servo_stop_sequence_selector DUT (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
    .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .servo_on_input_i, .positive_limit_input_i,
    .negative_limit_input_i, .control_power_on_i, .main_power_ok_i, .alarm_i, .alarm_estop_i,
    .full_closed_i, .extended_variant_i, .motor_speed_rpm_i, .motor_dir_neg_i,
    .encoder_resolution_i, .gear_denominator_i, .gear_select_i, .normal_torque_limit_i,
    .deviation_excess_i, .dynamic_brake_o, .servo_energized_o, .estop_active_o,
    .torque_limit_o, .inhibit_pos_o, .inhibit_neg_o, .zero_command_o, .deviation_clear_o,
    .run_inhibit_fault_o, .mains_undervoltage_fault_o, .excess_deviation_fault_o,
    .gear_num_o, .gear_den_o, .pulse_out_divider_o);

  host_ctrl_model host (.clk_i, .servo_on_input_o(servo_on_input_i),
    .positive_limit_input_o(positive_limit_input_i),
    .negative_limit_input_o(negative_limit_input_i));

  // Verdict and end of run
  task automatic end_sim();
    $display("checks %0d mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wt(input int n);
    repeat (n) @(posedge clk_i);
  endtask

  // Classic cycle: request held until ack is sampled, then released
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d,
                    output logic [31:0] rd);
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    do @(posedge clk_i); while (wb_ack_o !== 1'b1);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    wb(1'b1, a, d, x);
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] x;
    wb(1'b0, a, 32'h0, x);
    chk(x, e);
  endtask

  // Power-cycle settings load on the rising edge of control power
  task automatic pcycle();
    @(posedge clk_i);
    control_power_on_i <= 1'b0;
    @(posedge clk_i);
    control_power_on_i <= 1'b1;
    wt(3);
  endtask

  // Watchdog far beyond the expected several hundred cycles
  initial
  begin
    wt(20000);
    error_cnt++;
    end_sim();
  end

  // Main sequence
  initial
  begin
    logic est;
    logic [3:0] s;
    wt(5);
    rst_i <= 1'b0;
    rdc(ADDR_OT_SETUP, 32'h1);
    rdc(ADDR_LV_TRIP, 32'h1);
    rdc(ADDR_SOFF_SEQ, 32'h0);
    rdc(8'h3c, 32'h0);
    wr(ADDR_GEAR2, 32'h40000000);
    wr(ADDR_GEAR2, 32'h40000001);
    rdc(ADDR_GEAR2, 32'h40000000);
    wr(ADDR_GEAR2, 32'h5);
    wr(ADDR_GEAR3, 32'h0);
    gear_select_i <= 2'h1;
    wt(3);
    chk(gear_num_o, 32'h5);
    gear_select_i <= 2'h2;
    wt(3);
    chk(gear_num_o, 32'h00020000);
    full_closed_i <= 1'b1;
    wt(3);
    chk(gear_num_o, 32'h1);
    chk(gear_den_o, 32'h1);
    full_closed_i <= 1'b0;
    gear_select_i <= 2'h1;
    wr(ADDR_PPR, 32'h3e8);
    wt(3);
    chk(gear_num_o == 31'h5, 1'b0);
    wr(ADDR_PULSE_DIV, 32'h40000);
    wr(ADDR_PULSE_DIV, 32'h40001);
    wt(2);
    chk(pulse_out_divider_o, 32'h0);
    pcycle();
    chk(pulse_out_divider_o, 32'h40000);
    extended_variant_i <= 1'b1;
    wr(ADDR_PULSE_DIV, 32'h100000);
    rdc(ADDR_PULSE_DIV, 32'h100000);
    // Every servo-off sequence, with the 30 r/min boundary
    host.drive(1'b1, 1'b0, 1'b0, 0);
    wt(6);
    for (int v = 0; v < 10; v++)
    begin
      s = v[3:0];
      est = s > 4'h7;
      wr(ADDR_SOFF_SEQ, {28'h0, s});
      wr(ADDR_ESTOP_TRQ, (s == 4'h9) ? 32'h0c8 : 32'h0);
      motor_speed_rpm_i <= 16'h03e8;
      host.drive(1'b0, 1'b0, 1'b0, v % 3);
      wt(8);
      chk(estop_active_o, est);
      chk(servo_energized_o, est);
      chk(deviation_clear_o, s[3:2] != 2'b01);
      if (est)
        chk(torque_limit_o, (s == 4'h9) ? 32'h0c8 : 32'h12c);
      motor_speed_rpm_i <= 16'h001e;
      wt(5);
      if (!est)
        chk(dynamic_brake_o, !s[0]);
      chk(estop_active_o, est);
      motor_speed_rpm_i <= 16'h001d;
      wt(5);
      chk(dynamic_brake_o, est ? !s[0] : !s[1]);
      if (s == 4'h4)
      begin
        deviation_excess_i <= 1'b1;
        wt(2);
        chk(excess_deviation_fault_o, 1'b1);
        deviation_excess_i <= 1'b0;
      end
      host.drive(1'b1, 1'b0, 1'b0, 0);
      wt(6);
    end
    // Alarm and mains loss while servo is off
    wr(ADDR_SOFF_SEQ, 32'h3);
    wr(ADDR_PLOSS_SEQ, 32'h4);
    wr(ADDR_LV_TRIP, 32'h0);
    host.drive(1'b0, 1'b0, 1'b0, 1);
    wt(8);
    chk(dynamic_brake_o, 1'b0);
    alarm_i <= 1'b1;
    wt(5);
    chk(dynamic_brake_o, 1'b1);
    alarm_i <= 1'b0;
    main_power_ok_i <= 1'b0;
    wt(6);
    chk(dynamic_brake_o, 1'b1);
    chk(deviation_clear_o, 1'b0);
    wr(ADDR_ALARM_SEQ, 32'h3);
    alarm_i <= 1'b1;
    wt(5);
    chk(dynamic_brake_o, 1'b0);
    alarm_i <= 1'b0;
    main_power_ok_i <= 1'b1;
    // Mains loss with servo on, trip off and on
    host.drive(1'b1, 1'b0, 1'b0, 0);
    wt(6);
    main_power_ok_i <= 1'b0;
    wt(6);
    chk(mains_undervoltage_fault_o, 1'b0);
    main_power_ok_i <= 1'b1;
    wr(ADDR_LV_TRIP, 32'h1);
    main_power_ok_i <= 1'b0;
    wt(6);
    chk(mains_undervoltage_fault_o, 1'b1);
    main_power_ok_i <= 1'b1;
    alarm_i <= 1'b1;
    wt(5);
    alarm_i <= 1'b0;
    // Over-travel inhibit: default sequence brakes and keeps deviation, then emergency stop
    wr(ADDR_OT_SETUP, 32'h0);
    pcycle();
    motor_speed_rpm_i <= 16'h03e8;
    host.drive(1'b1, 1'b1, 1'b0, 2);
    wt(8);
    chk(dynamic_brake_o, 1'b1);
    chk(deviation_clear_o, 1'b0);
    host.drive(1'b1, 1'b0, 1'b0, 0);
    wt(4);
    wr(ADDR_OT_SEQ, 32'h2);
    pcycle();
    host.drive(1'b1, 1'b1, 1'b0, 2);
    wt(8);
    chk(estop_active_o, 1'b1);
    chk(deviation_clear_o, 1'b1);
    motor_speed_rpm_i <= 16'h001d;
    wt(5);
    chk(zero_command_o, 1'b1);
    chk(inhibit_pos_o, 1'b1);
    chk(inhibit_neg_o, 1'b0);
    host.drive(1'b1, 1'b0, 1'b0, 0);
    wr(ADDR_OT_SETUP, 32'h2);
    host.drive(1'b1, 1'b0, 1'b1, 0);
    wt(6);
    chk(run_inhibit_fault_o, 1'b0);
    pcycle();
    wt(4);
    chk(run_inhibit_fault_o, 1'b1);
    end_sim();
  end
endmodule
